// ### core/rg_reset_gen.sv
// How it works
// - any of four sources resets whole device, the monitor only when self-clock is off
// - power-on and low-voltage entry asynchronous, pin and monitor entry clocked, exit counted on clock
// - low-voltage and monitor outrank external pin
// - running sequence yields only to higher priority
// - equal priority event restarts running sequence
// - power-on release after 16420 clock periods
// - low-voltage or monitor release after 16420
// - external pin release after 70 periods
// - power-on sets its flag, interrupt low
// - low-voltage rise sets flag, interrupt low
// - monitor failure rise sets flag when self-clock is off, interrupt low
// - external pin assertion sets flag, interrupt low
// - interrupt released only when all flags zero
// - interface straps latched during reset window
// - host clock bit set only for 11
// - clock output straps latched into division field
// - strap pads become outputs after release
// - rc window timeout gives self-clock or reset
// - no failure when disabled or edges arrive
// - write one clears flag, zero no effect
// - power-on or low-voltage masks monitor and pin flags
// - host clock bit selects host clock input
//
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module rg_reset_gen #(
  parameter int POR_DELAY = rg_pkg::POR_DELAY_CYC,
  parameter int EXT_DELAY = rg_pkg::EXT_DELAY_CYC,
  parameter int CM_DELAY = rg_pkg::CLKMON_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic lowVoltRst,
  input wire logic extResetPinN,
  input wire logic oscRefClock,
  input wire logic [rg_pkg::ADDR_W-1:0] addr,
  input wire logic [rg_pkg::DATA_W-1:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  output logic [rg_pkg::DATA_W-1:0] rdData,
  output logic sysRstN,
  output logic ctrlIrqN,
  output logic hostClockSource,
  output logic [1:0] clkoutDivValue,
  output logic selfClockMode,
  input wire logic [1:0] phyTxDataIn,
  output logic [1:0] phyTxDataOut,
  output logic [1:0] phyTxDataOe,
  input wire logic [1:0] phyTxDataFunc,
  input wire logic [1:0] debugStrobeIn,
  output logic [1:0] debugStrobeOut,
  output logic [1:0] debugStrobeOe,
  input wire logic [1:0] debugStrobeFunc
);
  import rg_pkg::*;

  localparam int HI_LAST = POR_DELAY - 1;
  localparam int LO_LAST = EXT_DELAY - 1;
  localparam int CM_LAST = CM_DELAY - 1;
  localparam int CNT_W = $clog2(POR_DELAY + 1);
  localparam int CM_W = $clog2(CM_DELAY + 1);
  localparam int SYNC_W = 7;
  // pin bundle after reset: external pin idles high, all others low
  localparam logic [SYNC_W-1:0] SYNC_RST = 7'h04;

  // ---------------- pin synchronisers ----------------
  logic [SYNC_W-1:0] pinRaw; // every asynchronous pin in one bundle
  logic [SYNC_W-1:0] sync1_ff; // first stage, read only by stage two
  logic [SYNC_W-1:0] sync2_ff; // usable, synchronised levels
  logic refSync; // oscillator reference sample
  logic lvSync; // low-voltage level
  logic extSync; // external pin level, low means reset
  logic [1:0] ifSelSync; // interface select straps
  logic [1:0] clkSelSync; // clock output select straps

  assign pinRaw = {debugStrobeIn, phyTxDataIn, extResetPinN, lowVoltRst, oscRefClock};
  assign refSync = sync2_ff[0];
  assign lvSync = sync2_ff[1];
  assign extSync = sync2_ff[2];
  assign ifSelSync = sync2_ff[4:3];
  assign clkSelSync = sync2_ff[6:5];

  // two flops per pin; pad and pin levels are foreign to clk
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_ff <= SYNC_RST; // idle pin level, so no false fall after reset
      sync2_ff <= SYNC_RST;
    end else begin
      sync1_ff <= pinRaw;
      sync2_ff <= sync1_ff;
    end
  end

  // ---------------- clock monitor ----------------
  logic [CM_W-1:0] cmCnt_ff, nxt_cmCnt; // cycles since last reference edge
  logic refPrev_ff, nxt_refPrev; // for edge detection
  logic cmFail_ff, nxt_cmFail; // no edge inside the window
  logic cmRstPrev_ff, nxt_cmRstPrev; // previous reset-request level
  logic selfClockMode_ff, nxt_selfClockMode; // failure absorbed by self clock
  logic [1:0] ctrl_ff, nxt_ctrl; // monitor enable and self-clock enable
  logic refEdge;
  logic cmRstLvl; // failure that asks for a reset
  logic cmRise;

  assign refEdge = refSync ^ refPrev_ff;
  assign cmRstLvl = cmFail_ff & ~ctrl_ff[SC_EN_BIT];
  assign cmRise = cmRstLvl & ~cmRstPrev_ff;

  // the window is counted on clk here; a true rc delay lives in analogue
  always_comb begin
    nxt_refPrev = refSync;
    nxt_cmRstPrev = cmRstLvl;
    nxt_cmCnt = cmCnt_ff;
    nxt_cmFail = 1'b0;
    if (!ctrl_ff[CM_EN_BIT] || refEdge) begin
      nxt_cmCnt = '0;
    end else if (cmCnt_ff != CM_W'(CM_LAST)) begin
      nxt_cmCnt = cmCnt_ff + CM_W'(1);
    end else begin
      nxt_cmFail = 1'b1;
    end
    nxt_selfClockMode = nxt_cmFail & ctrl_ff[SC_EN_BIT];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmCnt_ff <= '0;
      refPrev_ff <= 1'b0;
      cmFail_ff <= 1'b0;
      cmRstPrev_ff <= 1'b0;
      selfClockMode_ff <= 1'b0;
    end else begin
      cmCnt_ff <= nxt_cmCnt;
      refPrev_ff <= nxt_refPrev;
      cmFail_ff <= nxt_cmFail;
      cmRstPrev_ff <= nxt_cmRstPrev;
      selfClockMode_ff <= nxt_selfClockMode;
    end
  end

  // ---------------- reset sequencer ----------------
  rg_state_t state_ff, nxt_state; // sequence in progress
  logic [CNT_W-1:0] relCnt_ff, nxt_relCnt; // release delay counter
  logic lvPrev_ff, nxt_lvPrev;
  logic extPrev_ff, nxt_extPrev;
  logic hiActive; // a high priority source is present
  logic hiEvent; // a new high priority source appeared
  logic extActive;
  logic extFall;
  logic lvRise;
  logic hardRstN; // asynchronous entry path
  logic nxt_sysRstN;

  assign lvRise = lvSync & ~lvPrev_ff;
  assign extFall = extPrev_ff & ~extSync;
  assign extActive = ~extSync;
  assign hiActive = lvSync | cmRstLvl;
  assign hiEvent = lvRise | cmRise;
  // power-on and low voltage pull reset with no clock running
  assign hardRstN = rst_n & ~lowVoltRst;

  // priority: high sources preempt, the external pin never preempts them
  always_comb begin
    nxt_state = state_ff;
    nxt_relCnt = relCnt_ff;
    nxt_lvPrev = lvSync;
    nxt_extPrev = extSync;
    unique case (state_ff)
      ST_RUN: begin
        if (hiActive) begin
          nxt_state = ST_HOLD_HI;
        end else if (extActive) begin
          nxt_state = ST_HOLD_LO;
        end
      end
      ST_HOLD_HI: begin
        nxt_relCnt = '0;
        if (!hiActive) begin
          nxt_state = ST_DELAY_HI;
        end
      end
      ST_DELAY_HI: begin
        // external pin is lower ranked and is ignored here
        if (hiActive || hiEvent) begin
          nxt_state = ST_HOLD_HI;
        end else if (relCnt_ff == CNT_W'(HI_LAST)) begin
          nxt_state = ST_RUN;
        end else begin
          nxt_relCnt = relCnt_ff + CNT_W'(1);
        end
      end
      ST_HOLD_LO: begin
        nxt_relCnt = '0;
        if (hiActive) begin
          nxt_state = ST_HOLD_HI;
        end else if (!extActive) begin
          nxt_state = ST_DELAY_LO;
        end
      end
      ST_DELAY_LO: begin
        if (hiActive) begin
          nxt_state = ST_HOLD_HI;
        end else if (extActive) begin
          nxt_state = ST_HOLD_LO;
        end else if (relCnt_ff == CNT_W'(LO_LAST)) begin
          nxt_state = ST_RUN;
        end else begin
          nxt_relCnt = relCnt_ff + CNT_W'(1);
        end
      end
    endcase
    nxt_sysRstN = (nxt_state == ST_RUN);
  end

  // power-on release counts from the end of rst_n
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_DELAY_HI;
      relCnt_ff <= '0;
      lvPrev_ff <= 1'b0;
      extPrev_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      relCnt_ff <= nxt_relCnt;
      lvPrev_ff <= nxt_lvPrev;
      extPrev_ff <= nxt_extPrev;
    end
  end

  // ---------------- system reset and pads ----------------
  logic sysRstN_ff;
  logic [1:0] phyTxDataOut_ff, nxt_phyTxDataOut;
  logic [1:0] phyTxDataOe_ff, nxt_phyTxDataOe;
  logic [1:0] debugStrobeOut_ff, nxt_debugStrobeOut;
  logic [1:0] debugStrobeOe_ff, nxt_debugStrobeOe;

  // pads listen as straps during reset, drive function afterwards
  always_comb begin
    nxt_phyTxDataOut = nxt_sysRstN ? phyTxDataFunc : 2'h0;
    nxt_debugStrobeOut = nxt_sysRstN ? debugStrobeFunc : 2'h0;
    nxt_phyTxDataOe = {2{nxt_sysRstN}};
    nxt_debugStrobeOe = {2{nxt_sysRstN}};
  end

  // asynchronous entry, synchronous release
  always_ff @(posedge clk or negedge hardRstN) begin
    if (!hardRstN) begin
      sysRstN_ff <= 1'b0;
      phyTxDataOut_ff <= 2'h0;
      phyTxDataOe_ff <= 2'h0;
      debugStrobeOut_ff <= 2'h0;
      debugStrobeOe_ff <= 2'h0;
    end else begin
      sysRstN_ff <= nxt_sysRstN;
      phyTxDataOut_ff <= nxt_phyTxDataOut;
      phyTxDataOe_ff <= nxt_phyTxDataOe;
      debugStrobeOut_ff <= nxt_debugStrobeOut;
      debugStrobeOe_ff <= nxt_debugStrobeOe;
    end
  end

  // ---------------- straps ----------------
  logic hostClockSource_ff, nxt_hostClockSource;
  logic [1:0] clkoutDiv_ff, nxt_clkoutDiv;
  logic inWindow; // latching window: the release delay of any sequence

  assign inWindow = (state_ff == ST_DELAY_HI) || (state_ff == ST_DELAY_LO);

  // last sample before release wins, so the straps must be stable then
  always_comb begin
    nxt_hostClockSource = hostClockSource_ff;
    nxt_clkoutDiv = clkoutDiv_ff;
    if (inWindow) begin
      nxt_hostClockSource = &ifSelSync;
      nxt_clkoutDiv = clkSelSync;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hostClockSource_ff <= HCS_RST;
      clkoutDiv_ff <= DIV_RST;
    end else begin
      hostClockSource_ff <= nxt_hostClockSource;
      clkoutDiv_ff <= nxt_clkoutDiv;
    end
  end

  // ---------------- flags, control and interrupt ----------------
  logic lvFlag_ff, nxt_lvFlag;
  logic cmFlag_ff, nxt_cmFlag;
  logic porFlag_ff, nxt_porFlag;
  logic extFlag_ff, nxt_extFlag;
  logic ctrlIrqN_ff, nxt_ctrlIrqN;
  logic wrStatus;
  logic wrCtrl;

  assign wrStatus = wrEn && (addr == STATUS_OFS);
  assign wrCtrl = wrEn && (addr == CTRL_OFS);

  // a set in the clearing cycle wins over the clear
  always_comb begin
    nxt_lvFlag = lvRise | (lvFlag_ff & ~(wrStatus & wrData[LV_BIT]));
    nxt_cmFlag = cmRise | (cmFlag_ff & ~(wrStatus & wrData[CM_BIT]));
    nxt_porFlag = porFlag_ff & ~(wrStatus & wrData[POR_BIT]);
    nxt_extFlag = extFall | (extFlag_ff & ~(wrStatus & wrData[EXT_BIT]));
    nxt_ctrlIrqN = ~(nxt_lvFlag | nxt_cmFlag | nxt_porFlag | nxt_extFlag);
    nxt_ctrl = wrCtrl ? wrData[1:0] : ctrl_ff;
  end

  // flags live through system reset so software can see the cause
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lvFlag_ff <= LV_FLAG_RST;
      cmFlag_ff <= CM_FLAG_RST;
      porFlag_ff <= POR_FLAG_RST;
      extFlag_ff <= EXT_FLAG_RST;
      ctrlIrqN_ff <= 1'b0;
      ctrl_ff <= CTRL_RST;
    end else begin
      lvFlag_ff <= nxt_lvFlag;
      cmFlag_ff <= nxt_cmFlag;
      porFlag_ff <= nxt_porFlag;
      extFlag_ff <= nxt_extFlag;
      ctrlIrqN_ff <= nxt_ctrlIrqN;
      ctrl_ff <= nxt_ctrl;
    end
  end

  // ---------------- read port ----------------
  logic [DATA_W-1:0] rdData_ff, nxt_rdData;
  logic maskLow; // power-on or low voltage hides the weaker causes

  assign maskLow = lvFlag_ff | porFlag_ff;

  // data stand for exactly one cycle, unmapped reads give zero
  always_comb begin
    nxt_rdData = '0;
    if (rdEn) begin
      if (addr == CTRL_OFS) begin
        nxt_rdData[1:0] = ctrl_ff;
      end else if (addr == STATUS_OFS) begin
        nxt_rdData[LV_BIT] = lvFlag_ff;
        nxt_rdData[CM_BIT] = cmFlag_ff & ~maskLow;
        nxt_rdData[POR_BIT] = porFlag_ff;
        nxt_rdData[EXT_BIT] = extFlag_ff & ~maskLow;
        nxt_rdData[HCS_BIT] = hostClockSource_ff;
        nxt_rdData[DIV_LSB+1:DIV_LSB] = clkoutDiv_ff;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData_ff <= '0;
    end else begin
      rdData_ff <= nxt_rdData;
    end
  end

  // ---------------- outputs ----------------
  assign rdData = rdData_ff;
  assign sysRstN = sysRstN_ff;
  assign ctrlIrqN = ctrlIrqN_ff;
  assign hostClockSource = hostClockSource_ff;
  assign clkoutDivValue = clkoutDiv_ff;
  assign selfClockMode = selfClockMode_ff;
  assign phyTxDataOut = phyTxDataOut_ff;
  assign phyTxDataOe = phyTxDataOe_ff;
  assign debugStrobeOut = debugStrobeOut_ff;
  assign debugStrobeOe = debugStrobeOe_ff;

  // ---------------- checks ----------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence sLoDone;
    (state_ff == ST_DELAY_LO) && (relCnt_ff == CNT_W'(LO_LAST)) && !hiActive && !extActive;
  endsequence

  sequence sHiDone;
    (state_ff == ST_DELAY_HI) && (relCnt_ff == CNT_W'(HI_LAST)) && !hiActive && !hiEvent;
  endsequence

  AST_LV_HOLDS: assert property (lvSync |=> !sysRstN_ff)
    else $error("low voltage did not hold system reset");
  AST_EXT_ENTRY: assert property ($fell(extSync) |=> !sysRstN_ff && extFlag_ff)
    else $error("external pin did not reset or flag");
  AST_LO_RELEASE: assert property (sLoDone |=> sysRstN_ff)
    else $error("external release not on time");
  AST_HI_RELEASE: assert property ($rose(sysRstN_ff) && $past(state_ff == ST_DELAY_HI)
    |-> $past(relCnt_ff) == CNT_W'(HI_LAST))
    else $error("high priority release early");
  AST_HI_DONE: assert property (sHiDone |=> sysRstN_ff)
    else $error("power-on release not on time");
  AST_PRIORITY: assert property ((state_ff == ST_DELAY_LO) && hiActive
    |=> state_ff == ST_HOLD_HI)
    else $error("high priority did not preempt");
  AST_RESTART: assert property ((state_ff == ST_DELAY_LO) && extActive && !hiActive
    |=> state_ff == ST_HOLD_LO ##1 relCnt_ff == '0)
    else $error("equal priority did not restart");
  AST_IRQ_LOW: assert property ((lvFlag_ff || cmFlag_ff || porFlag_ff || extFlag_ff)
    |-> !ctrlIrqN_ff)
    else $error("interrupt released with a flag set");
  AST_W1C: assert property (wrStatus && wrData[LV_BIT] && !lvRise |=> !lvFlag_ff)
    else $error("write one did not clear flag");
  AST_ECS: assert property ($rose(sysRstN_ff) |-> hostClockSource_ff == &$past(ifSelSync))
    else $error("host clock bit not from straps");
  AST_PAD_OE: assert property (!sysRstN_ff |-> phyTxDataOe_ff == 2'h0 && debugStrobeOe_ff == 2'h0)
    else $error("strap pad driven during reset");
  AST_CM_OFF: assert property (!ctrl_ff[CM_EN_BIT] |=> !cmFail_ff)
    else $error("monitor failed while disabled");
  AST_MASK: assert property (rdEn && addr == STATUS_OFS && maskLow
    |=> rdData_ff[CM_BIT] == 1'b0 && rdData_ff[EXT_BIT] == 1'b0)
    else $error("masked flags read as one");
endmodule // rg_reset_gen
`default_nettype wire

// ### inc/rg_pkg.sv
// shared constants for the reset generator with strap latch
package rg_pkg;
  // reference clock of the sequencer (oscillator input)
  localparam int CLK_PERIOD_NS = 10;
  // release delays, counted in oscillator input periods
  localparam int POR_DELAY_CYC = 16420;
  localparam int EXT_DELAY_CYC = 70;
  // clock monitor rc window, longest time so rounded down
  localparam int CLKMON_RC_NS = 2000;
  localparam int CLKMON_CYC = CLKMON_RC_NS / CLK_PERIOD_NS;
  // register port geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  // register offsets
  localparam logic [7:0] CTRL_OFS = 8'hE0;
  localparam logic [7:0] STATUS_OFS = 8'hE2;
  // control register fields
  localparam int CM_EN_BIT = 0;
  localparam int SC_EN_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  // status register fields
  localparam int LV_BIT = 0;
  localparam int CM_BIT = 1;
  localparam int POR_BIT = 2;
  localparam int EXT_BIT = 3;
  localparam int HCS_BIT = 8;
  localparam int DIV_LSB = 9;
  // flag reset values, power-on flag comes up set
  localparam logic LV_FLAG_RST = 1'h0;
  localparam logic CM_FLAG_RST = 1'h0;
  localparam logic POR_FLAG_RST = 1'h1;
  localparam logic EXT_FLAG_RST = 1'h0;
  // strap results before any latch
  localparam logic HCS_RST = 1'h0;
  localparam logic [1:0] DIV_RST = 2'h0;
  // sequencer states
  typedef enum logic [2:0] {
    ST_RUN,
    ST_HOLD_HI,
    ST_DELAY_HI,
    ST_HOLD_LO,
    ST_DELAY_LO
  } rg_state_t;
endpackage

// ### verif/rg_far_side.sv
`timescale 1ns/1ps
`default_nettype none
// far side of the reset generator: reset pin, strap resistors, reference clock
module rg_far_side (
  input wire logic clk,
  input wire logic sysRstN,
  input wire logic pressPin,
  input wire logic refRun,
  input wire logic [1:0] ifSel,
  input wire logic [1:0] clkSel,
  input wire logic [1:0] phyTxDataOut,
  input wire logic [1:0] phyTxDataOe,
  input wire logic [1:0] debugStrobeOut,
  input wire logic [1:0] debugStrobeOe,
  output logic extResetPinN,
  output logic oscRefClock,
  output logic [1:0] phyTxDataIn,
  output logic [1:0] debugStrobeIn
);
  logic refClk_ff; // reference toggle, frozen when refRun is low
  logic [1:0] ifDrv; // interface strap offered to the pads
  logic [1:0] csDrv; // clock-output strap offered to the pads
  initial refClk_ff = 1'b0;
  // a stalled reference is what trips the monitor window
  always @(posedge clk) begin
    if (refRun) begin
      refClk_ff <= ~refClk_ff;
    end
  end
  assign oscRefClock = refClk_ff;
  assign extResetPinN = ~pressPin;
  // straps stay valid for the whole reset, then only the pull-down remains
  assign ifDrv = sysRstN ? 2'h0 : ifSel;
  assign csDrv = sysRstN ? 2'h0 : clkSel;
  // pad level: the device drive wins bit by bit where it is enabled
  assign phyTxDataIn = (phyTxDataOe & phyTxDataOut) | (~phyTxDataOe & ifDrv);
  assign debugStrobeIn = (debugStrobeOe & debugStrobeOut) | (~debugStrobeOe & csDrv);
endmodule // rg_far_side
`default_nettype wire

// ### verif/rg_reset_gen_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module rg_reset_gen_tb_top;
  import rg_pkg::*;
  localparam int PD = 20; // shortened high priority release delay
  localparam int ED = 8; // shortened external pin release delay
  localparam int CD = 10; // shortened monitor window
  logic clk, rst_n, lowVoltRst, wrEn, rdEn, sysRstN, ctrlIrqN, selfClockMode;
  logic hostClockSource, extResetPinN, oscRefClock, pressPin, refRun;
  logic [7:0] addr; // register address
  logic [15:0] wrData, rdData; // register data
  logic [1:0] clkoutDivValue, ifSel, clkSel;
  logic [1:0] phyTxDataIn, phyTxDataOut, phyTxDataOe, phyTxDataFunc;
  logic [1:0] debugStrobeIn, debugStrobeOut, debugStrobeOe, debugStrobeFunc;
  int checks = 0; // comparisons made
  int n_mismatch = 0; // comparisons failed
  rg_reset_gen #(.POR_DELAY(PD), .EXT_DELAY(ED), .CM_DELAY(CD)) rg_reset_gen_inst (
    .clk(clk), .rst_n(rst_n), .lowVoltRst(lowVoltRst), .extResetPinN(extResetPinN),
    .oscRefClock(oscRefClock), .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn),
    .rdData(rdData), .sysRstN(sysRstN), .ctrlIrqN(ctrlIrqN),
    .hostClockSource(hostClockSource), .clkoutDivValue(clkoutDivValue),
    .selfClockMode(selfClockMode), .phyTxDataIn(phyTxDataIn), .phyTxDataOut(phyTxDataOut),
    .phyTxDataOe(phyTxDataOe), .phyTxDataFunc(phyTxDataFunc), .debugStrobeIn(debugStrobeIn),
    .debugStrobeOut(debugStrobeOut), .debugStrobeOe(debugStrobeOe),
    .debugStrobeFunc(debugStrobeFunc));
  rg_far_side rg_far_side_inst (
    .clk(clk), .sysRstN(sysRstN), .pressPin(pressPin), .refRun(refRun), .ifSel(ifSel),
    .clkSel(clkSel), .phyTxDataOut(phyTxDataOut), .phyTxDataOe(phyTxDataOe),
    .debugStrobeOut(debugStrobeOut), .debugStrobeOe(debugStrobeOe),
    .extResetPinN(extResetPinN), .oscRefClock(oscRefClock), .phyTxDataIn(phyTxDataIn),
    .debugStrobeIn(debugStrobeIn));
  // free running oscillator input
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // verdict and end of run, shared with the watchdog
  task automatic test_done();
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrEn <= 1'b1;
    @(posedge clk);
    wrEn <= 1'b0;
  endtask
  // one-cycle read strobe, data only in the following cycle
  task automatic rdChk(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clk);
    rdEn <= 1'b0;
    #1 chk(rdData, e);
  endtask
  // bounded wait for a reset level, the span must fall in the window
  task automatic waitRst(input logic lvl, input int lo, input int hi);
    int n;
    n = 0;
    while (sysRstN !== lvl && n <= hi) begin
      @(posedge clk);
      #1 n++;
    end
    chk(16'(n >= lo && n <= hi), 16'h1);
  endtask
  // pads: straps while in reset, functional drive afterwards
  task automatic padChk();
    chk({12'h0, phyTxDataOe, debugStrobeOe}, sysRstN ? 16'h000F : 16'h0000);
    if (sysRstN === 1'b1) begin
      chk({12'h0, phyTxDataOut, debugStrobeOut}, {12'h0, phyTxDataFunc, debugStrobeFunc});
    end
  endtask
  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    test_done();
  end
  initial begin
    rst_n = 1'b0;
    lowVoltRst = 1'b0;
    addr = 8'h00;
    wrData = 16'h0000;
    wrEn = 1'b0;
    rdEn = 1'b0;
    pressPin = 1'b0;
    refRun = 1'b1;
    ifSel = 2'h3;
    clkSel = 2'h2;
    phyTxDataFunc = 2'h1;
    debugStrobeFunc = 2'h2;
    // power-on
    repeat (10) @(posedge clk);
    #1 chk({14'h0, sysRstN, ctrlIrqN}, 16'h0000);
    padChk();
    @(posedge clk);
    rst_n <= 1'b1;
    waitRst(1'b1, PD, PD + 6);
    padChk();
    chk({13'h0, hostClockSource, clkoutDivValue}, 16'h0006);
    rdChk(STATUS_OFS, 16'h0504);
    rdChk(CTRL_OFS, 16'h0000);
    wr(8'h10, 16'hFFFF);
    rdChk(8'h10, 16'h0000);
    rdChk(CTRL_OFS, 16'h0000);
    wr(STATUS_OFS, 16'h0000);
    rdChk(STATUS_OFS, 16'h0504);
    wr(STATUS_OFS, 16'h0004);
    rdChk(STATUS_OFS, 16'h0500);
    chk({15'h0, ctrlIrqN}, 16'h0001);
    $display("test power_on done");
    // external pin, strap patterns 1 to 3 on both strap pairs
    for (int i = 1; i <= 3; i++) begin
      @(posedge clk);
      ifSel <= 2'(i);
      clkSel <= 2'(i);
      pressPin <= 1'b1;
      waitRst(1'b0, 1, 6);
      padChk();
      repeat (4) @(posedge clk);
      #1 chk({15'h0, ctrlIrqN}, 16'h0000);
      @(posedge clk);
      pressPin <= 1'b0;
      waitRst(1'b1, ED, ED + 6);
      chk({13'h0, hostClockSource, clkoutDivValue}, {13'h0, i == 3, 2'(i)});
      rdChk(STATUS_OFS, {5'h0, 2'(i), i == 3, 8'h08});
      wr(STATUS_OFS, 16'h0008);
      rdChk(STATUS_OFS, {5'h0, 2'(i), i == 3, 8'h00});
      chk({15'h0, ctrlIrqN}, 16'h0001);
    end
    $display("test external done");
    // low voltage takes over a pin sequence, pin events inside it are ignored
    @(posedge clk);
    ifSel <= 2'h1;
    clkSel <= 2'h0;
    pressPin <= 1'b1;
    waitRst(1'b0, 1, 6);
    @(posedge clk);
    lowVoltRst <= 1'b1;
    repeat (3) @(posedge clk);
    pressPin <= 1'b0;
    repeat (3) @(posedge clk);
    pressPin <= 1'b1;
    repeat (3) @(posedge clk);
    pressPin <= 1'b0;
    lowVoltRst <= 1'b0;
    // a pin sequence would have ended by now
    repeat (15) @(posedge clk);
    #1 chk({14'h0, sysRstN, ctrlIrqN}, 16'h0000);
    // equal priority event restarts the count
    @(posedge clk);
    lowVoltRst <= 1'b1;
    repeat (2) @(posedge clk);
    lowVoltRst <= 1'b0;
    waitRst(1'b1, PD, PD + 6);
    chk({13'h0, hostClockSource, clkoutDivValue}, 16'h0000);
    rdChk(STATUS_OFS, 16'h0001);
    wr(STATUS_OFS, 16'h0001);
    rdChk(STATUS_OFS, 16'h0008);
    wr(STATUS_OFS, 16'h0008);
    rdChk(STATUS_OFS, 16'h0000);
    chk({15'h0, ctrlIrqN}, 16'h0001);
    $display("test low_voltage done");
    // clock monitor: quiet while edges arrive, reset on a stall
    wr(CTRL_OFS, 16'h0001);
    repeat (3 * CD) @(posedge clk);
    #1 chk({15'h0, sysRstN}, 16'h0001);
    rdChk(STATUS_OFS, 16'h0000);
    @(posedge clk);
    refRun <= 1'b0;
    waitRst(1'b0, CD - 2, CD + 6);
    @(posedge clk);
    refRun <= 1'b1;
    waitRst(1'b1, PD, PD + 8);
    rdChk(STATUS_OFS, 16'h0002);
    wr(STATUS_OFS, 16'h0002);
    rdChk(CTRL_OFS, 16'h0001);
    // self-clock enabled: stall gives self clock mode instead of reset
    wr(CTRL_OFS, 16'h0003);
    @(posedge clk);
    refRun <= 1'b0;
    repeat (CD + 8) @(posedge clk);
    #1 chk({14'h0, selfClockMode, sysRstN}, 16'h0003);
    rdChk(STATUS_OFS, 16'h0000);
    chk({15'h0, ctrlIrqN}, 16'h0001);
    @(posedge clk);
    refRun <= 1'b1;
    $display("test clock_monitor done");
    test_done();
  end
endmodule // rg_reset_gen_tb_top
`default_nettype wire
